// ==== src/pmc_ctrl.sv ====
// pmc_ctrl.sv: power-mode and power-on reset controller with an axi4-lite register slave
// assumes: one clock aclk at 250 mhz; pins already synchronous except por and reset pin,
//          which pass a three-flop filter here; interrupt requests come from core-clock logic
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"

module pmc_ctrl #(
   parameter int unsigned POR_CYCLES = `PMC_POR_CYCLES  // power-on hold, shorten in simulation
) (
   input  wire logic             aclk,            // 250 mhz clock
   input  wire logic             aresetn,         // synchronous reset, active low
   input  wire pmc_pkg::pmc_axi_req_s axi_req,    // axi4-lite requests
   output pmc_pkg::pmc_axi_rsp_s axi_rsp,         // axi4-lite answers
   input  wire logic             supply_ok,       // digital supply above threshold, async
   input  wire logic             reset_pin,       // external reset pin, active high, async
   input  wire logic             irq_pending,     // any enabled interrupt pending
   input  wire logic             ictr_irq,        // interval counter interrupt
   input  wire logic             spi_irq,         // spi interrupt
   input  wire logic             ext_int0_irq,    // external interrupt 0 request
   input  wire logic             ictr_enable,     // interval counter enabled by software
   output pmc_pkg::pmc_ctrl_s    ctrl,            // clock and pin controls
   output pmc_pkg::pmc_state_e   mode             // present power mode
);
   import pmc_pkg::*;

   // pins from outside aclk are filtered before use; everything else is same-clock
   // a glitch shorter than one cycle never reaches the mode machine
   // three-flop input filters
   logic [2:0] sup_sync_q;    // supply ok chain
   logic [2:0] rst_sync_q;    // reset pin chain
   logic       sup_ok_q;      // filtered supply level
   logic       rst_pin_q;     // filtered reset pin level

   // software-visible state; only the low byte of each word is implemented
   // upper bits read as zero so wider writes are harmless
   // registers
   logic [7:0] power_control_reg_q;  // mode and wake enables
   logic [7:0] pll_control_reg_q;    // oscillator stop bit lives here
   logic [3:0] wake_src_q;           // last wake cause, sticky until written
   pmc_state_e state_q;              // power mode
   logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_q;  // release timer

   // one write and one read may be outstanding; no deeper queue is kept
   // because the master never issues more than that
   // axi slave state
   logic        aw_got_q;     // write address held
   logic        w_got_q;      // write data held
   logic [11:0] awaddr_q;     // captured write address
   logic [31:0] wdata_q;      // captured write data
   logic [3:0]  wstrb_q;      // captured strobes
   logic        bvalid_q;     // write response pending
   logic [1:0]  bresp_q;      // write response code
   logic        rvalid_q;     // read data pending
   logic [31:0] rdata_q;      // read data
   logic [1:0]  rresp_q;      // read response code

   logic wr_fire;             // both halves of a write present
   logic wr_ctrl;             // write hits control register
   logic wr_pll;              // write hits pll register
   logic wr_wake;             // write hits wake source register
   logic wake_pd;             // a power-down wake source fires
   logic mode_exit;           // leaving idle or power-down this cycle
   logic hard_reset;          // reset pin or low supply active

   // unmapped offsets answer with slverr rather than hanging the bus
   // shared by both channels so the two decodes cannot drift apart
   // known register offset check, used by read and write decode
   function automatic logic pmc_mapped(input logic [11:0] a);
      pmc_mapped = (a == `PMC_OFS_PWR_CTRL) || (a == `PMC_OFS_PLL_CTRL) ||
                   (a == `PMC_OFS_STATUS)   || (a == `PMC_OFS_WAKE_SRC);
   endfunction

   // input filters, change accepted when the last two stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sup_sync_q <= 3'h0;
         rst_sync_q <= 3'h0;
         sup_ok_q   <= 1'b0;
         rst_pin_q  <= 1'b0;
      end else begin
         sup_sync_q <= {sup_sync_q[1:0], supply_ok};
         rst_sync_q <= {rst_sync_q[1:0], reset_pin};
         if (sup_sync_q[2] == sup_sync_q[1]) begin
            sup_ok_q <= sup_sync_q[2];
         end
         if (rst_sync_q[2] == rst_sync_q[1]) begin
            rst_pin_q <= rst_sync_q[2];
         end
      end
   end

   // both sources share one path, so regs, mode and timer reset together
   // reset pin or low supply restarts everything except the bus channels and the input filters
   assign hard_reset = rst_pin_q || !sup_ok_q;

   // irq_pending is not used here: only these three sources survive power-down
   // the interval counter needs no enable bit to wake the part
   // wake sources for power-down; the spi and int0 paths gated by their enable bits
   assign wake_pd = ictr_irq
                  || (spi_irq && power_control_reg_q[`PMC_PC_SPI_WAKE])
                  || (ext_int0_irq && power_control_reg_q[`PMC_PC_INT0_WAKE]);

   // same-clock level inputs, so no filter delay on the wake path
   // idle ends on any enabled interrupt, power-down only on its own sources
   // exit from a low-power mode by interrupt
   assign mode_exit = ((state_q == PMC_ST_IDLE) && irq_pending) ||
                      ((state_q == PMC_ST_PDOWN) && wake_pd);

   // one-hot states; a bad code falls back to por rather than locking up
   // hard_reset outranks every transition, including a wake in the same cycle
   // power mode machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= PMC_ST_POR;
      end else if (hard_reset) begin
         state_q <= PMC_ST_POR;
      end else begin
         case (state_q)
            PMC_ST_POR: begin
               // release once the hold timer expires
               if (por_cnt_q == '0) begin
                  state_q <= PMC_ST_RUN;
               end
            end
            PMC_ST_RUN: begin
               // power-down wins if both bits are set in one write
               if (power_control_reg_q[`PMC_PC_PDOWN]) begin
                  state_q <= PMC_ST_PDOWN;
               end else if (power_control_reg_q[`PMC_PC_IDLE]) begin
                  state_q <= PMC_ST_IDLE;
               end
            end
            PMC_ST_IDLE: begin
               if (mode_exit) begin
                  state_q <= PMC_ST_RUN;
               end
            end
            PMC_ST_PDOWN: begin
               // interrupt return resumes after the entering instruction: pc was frozen
               if (mode_exit) begin
                  state_q <= PMC_ST_RUN;
               end
            end
            default: begin
               state_q <= PMC_ST_POR;  // illegal code recovers through reset
            end
         endcase
      end
   end

   // counts down only in por; zero means release
   // power-on release timer; a pin reset also reloads it, a simplification that costs
   // one extra hold after a manual reset but keeps a single release path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_cnt_q <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
      end else if (hard_reset) begin
         por_cnt_q <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
      end else if ((state_q == PMC_ST_POR) && (por_cnt_q != '0)) begin
         por_cnt_q <= por_cnt_q - 1'b1;
      end
   end

   // each half is latched on its own handshake; the commit waits for both
   // and for a free response slot, so a stalled bready stalls the next write
   // axi write channel capture, address and data in either order
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign wr_ctrl = wr_fire && (awaddr_q == `PMC_OFS_PWR_CTRL) && wstrb_q[0];
   assign wr_pll  = wr_fire && (awaddr_q == `PMC_OFS_PLL_CTRL) && wstrb_q[0];
   assign wr_wake = wr_fire && (awaddr_q == `PMC_OFS_WAKE_SRC) && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= `PMC_RESP_OKAY;
      end else begin
         // address half
         if (axi_req.awvalid && !aw_got_q) begin
            aw_got_q <= 1'b1;
            awaddr_q <= axi_req.awaddr;
         end
         // data half
         if (axi_req.wvalid && !w_got_q) begin
            w_got_q <= 1'b1;
            wdata_q <= axi_req.wdata;
            wstrb_q <= axi_req.wstrb;
         end
         // both present: commit and answer
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= pmc_mapped(awaddr_q) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // writes outside run are ignored so a sleeping core cannot retrigger a mode
   // power_control_reg: software sets, hardware clears mode bits on exit
   always_ff @(posedge aclk) begin
      if (!aresetn || hard_reset) begin
         power_control_reg_q <= `PMC_PWR_CTRL_RST;
      end else if (mode_exit) begin
         // exit clears mode bits; a write in this cycle is dropped so the core
         // does not drop straight back into the mode it just left
         power_control_reg_q[`PMC_PC_IDLE]  <= 1'b0;
         power_control_reg_q[`PMC_PC_PDOWN] <= 1'b0;
      end else if (wr_ctrl && (state_q == PMC_ST_RUN)) begin
         power_control_reg_q <= wdata_q[7:0];
      end
   end

   // the oscillator-stop bit acts only in power-down
   // pll_control_reg and wake cause record
   always_ff @(posedge aclk) begin
      if (!aresetn || hard_reset) begin
         pll_control_reg_q <= `PMC_PLL_CTRL_RST;
         wake_src_q        <= 4'h0;
      end else begin
         if (wr_pll) begin
            pll_control_reg_q <= wdata_q[7:0];
         end
         // set wins over a software clear in the same cycle
         if (mode_exit) begin
            wake_src_q <= {ext_int0_irq, spi_irq, ictr_irq, state_q == PMC_ST_IDLE};
         end else if (wr_wake) begin
            wake_src_q <= wake_src_q & ~wdata_q[3:0];
         end
      end
   end

   // data is sampled at address time, so a mode change during an rready stall
   // is not reflected in the word already returned
   // axi read channel, one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `PMC_RESP_OKAY;
      end else if (axi_req.arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= pmc_mapped(axi_req.araddr) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         case (axi_req.araddr)
            `PMC_OFS_PWR_CTRL: rdata_q <= {24'h000000, power_control_reg_q};
            `PMC_OFS_PLL_CTRL: rdata_q <= {24'h000000, pll_control_reg_q};
            `PMC_OFS_STATUS:   rdata_q <= {28'h0000000, state_q};
            `PMC_OFS_WAKE_SRC: rdata_q <= {28'h0000000, wake_src_q};
            default:           rdata_q <= 32'h0000_0000;  // unmapped reads zero
         endcase
      end else if (rvalid_q && axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ready outputs come from flops only, no input-to-output path
   // arready drops while a read answer is pending
   // bus answers; ready only while the half is not already held
   always_comb begin
      axi_rsp.awready = !aw_got_q;
      axi_rsp.wready  = !w_got_q;
      axi_rsp.bvalid  = bvalid_q;
      axi_rsp.bresp   = bresp_q;
      axi_rsp.arready = !rvalid_q;
      axi_rsp.rvalid  = rvalid_q;
      axi_rsp.rdata   = rdata_q;
      axi_rsp.rresp   = rresp_q;
   end

   // controls trail the mode by one edge; gating cells see glitch-free levels
   // strobes only matter while strobe_override is high
   // clock gating and pin controls registered from the mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= '{core_clk_en: 1'b0, pll_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b0,
                   ictr_clk_en: 1'b0, core_reset: 1'b1, hold_regs: 1'b0, dac_hiz: 1'b0,
                   addr_latch_strobe: 1'b0, prog_store_strobe: 1'b0, strobe_override: 1'b0};
      end else begin
         case (state_q)
            PMC_ST_POR: begin
               // core in reset, clocks running so the pll can settle
               ctrl <= '{core_clk_en: 1'b0, pll_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b0,
                         ictr_clk_en: 1'b0, core_reset: 1'b1, hold_regs: 1'b0, dac_hiz: 1'b0,
                         addr_latch_strobe: 1'b0, prog_store_strobe: 1'b0, strobe_override: 1'b0};
            end
            PMC_ST_IDLE: begin
               // core clock off, peripherals on, strobes high
               ctrl <= '{core_clk_en: 1'b0, pll_en: 1'b1, osc_en: 1'b1,
                         periph_clk_en: 1'b1, ictr_clk_en: ictr_enable,
                         core_reset: 1'b0, hold_regs: 1'b1, dac_hiz: 1'b0,
                         addr_latch_strobe: 1'b1, prog_store_strobe: 1'b1,
                         strobe_override: 1'b1};
            end
            PMC_ST_PDOWN: begin
               // everything off but the oscillator and, if enabled, the interval counter; the oscillator-stop bit stops both
               ctrl <= '{core_clk_en: 1'b0, pll_en: 1'b0,
                         osc_en: !pll_control_reg_q[`PMC_PLL_OSC_STOP],
                         periph_clk_en: 1'b0,
                         ictr_clk_en: ictr_enable && !pll_control_reg_q[`PMC_PLL_OSC_STOP],
                         core_reset: 1'b0, hold_regs: 1'b1, dac_hiz: 1'b1,
                         addr_latch_strobe: 1'b0, prog_store_strobe: 1'b0,
                         strobe_override: 1'b1};
            end
            default: begin
               // normal running
               ctrl <= '{core_clk_en: 1'b1, pll_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b1,
                         ictr_clk_en: ictr_enable, core_reset: 1'b0, hold_regs: 1'b0, dac_hiz: 1'b0,
                         addr_latch_strobe: 1'b0, prog_store_strobe: 1'b0, strobe_override: 1'b0};
            end
         endcase
      end
   end

   // status register reads the same one-hot code
   // present mode
   assign mode = state_q;

endmodule
`default_nettype wire

// ==== src/pmc_params.svh ====
// pmc_params.svh: offsets, field positions, reset values and timing for the power-mode controller
// assumes: included by the package, by the controller module and by the bench
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// register byte offsets on the axi4-lite slave
`define PMC_OFS_PWR_CTRL   12'h000
`define PMC_OFS_PLL_CTRL   12'h004
`define PMC_OFS_STATUS     12'h008
`define PMC_OFS_WAKE_SRC   12'h00c

// power_control_reg bit positions
`define PMC_PC_IDLE        0
`define PMC_PC_PDOWN       1
`define PMC_PC_SPI_WAKE    2
`define PMC_PC_INT0_WAKE   3

// pll_control_reg bit position
`define PMC_PLL_OSC_STOP   3

// reset values
`define PMC_PWR_CTRL_RST   8'h00
`define PMC_PLL_CTRL_RST   8'h00

// axi response codes
`define PMC_RESP_OKAY      2'b00
`define PMC_RESP_SLVERR    2'b10

// power-on release time
`define PMC_POR_HOLD_MS    128
`define PMC_CLK_MHZ        250
`define PMC_POR_CYCLES     (`PMC_POR_HOLD_MS * 1000 * `PMC_CLK_MHZ)

`endif

// ==== src/pmc_pkg.sv ====
// pmc_pkg.sv: types shared by the power-mode controller and its bench
// assumes: pmc_params.svh sits on the include path
`include "pmc_params.svh"

package pmc_pkg;

   // power modes, one-hot
   typedef enum logic [3:0] {
      PMC_ST_POR   = 4'b0001,  // held by power-on or pin reset
      PMC_ST_RUN   = 4'b0010,  // normal clocking
      PMC_ST_IDLE  = 4'b0100,  // core clock stopped
      PMC_ST_PDOWN = 4'b1000   // pll and core clock stopped
   } pmc_state_e;

   // axi4-lite write and read side from master
   typedef struct packed {
      logic        awvalid;    // write address valid
      logic [11:0] awaddr;     // write byte address
      logic        wvalid;     // write data valid
      logic [31:0] wdata;      // write data
      logic [3:0]  wstrb;      // byte enables
      logic        bready;     // response ready
      logic        arvalid;    // read address valid
      logic [11:0] araddr;     // read byte address
      logic        rready;     // read data ready
   } pmc_axi_req_s;

   // axi4-lite answers from slave
   typedef struct packed {
      logic        awready;    // write address taken
      logic        wready;     // write data taken
      logic        bvalid;     // write response valid
      logic [1:0]  bresp;      // write response
      logic        arready;    // read address taken
      logic        rvalid;     // read data valid
      logic [31:0] rdata;      // read data
      logic [1:0]  rresp;      // read response
   } pmc_axi_rsp_s;

   // clock and pin controls toward the chip
   typedef struct packed {
      logic core_clk_en;       // core clock gate
      logic pll_en;            // pll running
      logic osc_en;            // crystal oscillator running
      logic periph_clk_en;     // peripheral clock gate, not the interval counter
      logic ictr_clk_en;       // interval counter clock gate
      logic core_reset;        // core held in reset
      logic hold_regs;         // freeze core registers and port pins
      logic dac_hiz;           // converter output to high impedance
      logic addr_latch_strobe; // address-latch strobe level
      logic prog_store_strobe; // program-store strobe level
      logic strobe_override;   // strobes forced by this block
   } pmc_ctrl_s;

endpackage

// ==== sim/pmc_ctrl_checker.sv ====
// pmc_ctrl_checker.sv: port assertions for the power-mode controller
// assumes: bound to pmc_ctrl, one clock aclk, synchronous reset aresetn
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_checker
   import pmc_pkg::*;
#(
   parameter int unsigned POR_CYCLES = 20  // power-on hold length
) (
   input wire logic       aclk,         // clock
   input wire logic       aresetn,      // reset, active low
   input wire logic       supply_ok,    // supply good
   input wire logic       reset_pin,    // pin reset
   input wire logic       irq_pending,  // enabled interrupt
   input wire logic       ictr_irq,     // interval counter irq
   input wire logic       spi_irq,      // spi irq
   input wire logic       ext_int0_irq, // int0 irq
   input wire pmc_ctrl_s  ctrl,         // clock and pin controls
   input wire pmc_state_e mode          // present mode
);
   logic [31:0] por_cnt_q;  // consecutive cycles in por

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // length of the current por stretch, to bound its release
   always_ff @(posedge aclk) begin
      if (!aresetn || mode != PMC_ST_POR) begin
         por_cnt_q <= 32'h0;
      end else begin
         por_cnt_q <= por_cnt_q + 32'h1;
      end
   end

   // ctrl trails mode by one edge, so look after two samples
   sequence s_idle2; mode == PMC_ST_IDLE ##1 mode == PMC_ST_IDLE; endsequence
   sequence s_pd2; mode == PMC_ST_PDOWN ##1 mode == PMC_ST_PDOWN; endsequence
   // input filters are a few flops deep, so wait for them to settle
   sequence s_quiet; (supply_ok && !reset_pin)[*8]; endsequence

   property p_idle_clk;
      s_idle2 |-> ctrl.osc_en && !ctrl.core_clk_en && ctrl.periph_clk_en && !ctrl.dac_hiz;
   endproperty
   property p_idle_strb;
      s_idle2 |-> ctrl.strobe_override && ctrl.addr_latch_strobe && ctrl.prog_store_strobe;
   endproperty
   property p_pd_ctrl;
      s_pd2 |-> !ctrl.pll_en && !ctrl.core_clk_en && !ctrl.periph_clk_en && ctrl.dac_hiz
                && !ctrl.addr_latch_strobe && !ctrl.prog_store_strobe;
   endproperty
   property p_idle_exit; mode == PMC_ST_IDLE && irq_pending |=> mode != PMC_ST_IDLE; endproperty
   property p_ictr_wake; mode == PMC_ST_PDOWN && ictr_irq |=> mode != PMC_ST_PDOWN; endproperty
   property p_pd_hold;
      s_quiet ##0 (mode == PMC_ST_PDOWN && !ictr_irq && !spi_irq && !ext_int0_irq) |=> mode == PMC_ST_PDOWN;
   endproperty
   property p_supply; (!supply_ok)[*8] |-> mode == PMC_ST_POR; endproperty
   property p_pin; reset_pin[*8] |-> mode == PMC_ST_POR; endproperty
   property p_por_time;
      $rose(mode == PMC_ST_RUN) && $past(mode) == PMC_ST_POR |-> por_cnt_q >= POR_CYCLES;
   endproperty

   a_idle_clk: assert property (p_idle_clk) else $error("idle clocking wrong");
   a_idle_strb: assert property (p_idle_strb) else $error("idle strobes not high");
   a_pd_ctrl: assert property (p_pd_ctrl) else $error("power-down controls wrong");
   a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");
   a_ictr_wake: assert property (p_ictr_wake) else $error("no wake on interval counter");
   a_pd_hold: assert property (p_pd_hold) else $error("power-down left without cause");
   a_supply: assert property (p_supply) else $error("low supply not held in por");
   a_pin: assert property (p_pin) else $error("pin reset not held in por");
   a_por_time: assert property (p_por_time) else $error("por released too early");
endmodule
`default_nettype wire

// ==== sim/tb_pmc_ctrl.sv ====
// tb_pmc_ctrl.sv: directed bench for the power-mode controller over axi4-lite
// assumes: pmc_pkg compiled first, pmc_params.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
   $display("wrong value %s: expected %h seen %h", nm, ex, gt); end end
module tb_pmc_ctrl;
   import pmc_pkg::*;
   localparam int PORC = 20;                  // shortened power-on hold
   localparam logic [11:0] A_PC = `PMC_OFS_PWR_CTRL;
   localparam logic [11:0] A_PLL = `PMC_OFS_PLL_CTRL;
   localparam logic [11:0] A_ST = `PMC_OFS_STATUS;
   localparam logic [11:0] A_WK = `PMC_OFS_WAKE_SRC;
   localparam logic [1:0] OK = `PMC_RESP_OKAY;
   logic         aclk;        // 250 mhz clock
   logic         aresetn;     // reset, active low
   logic         supply_ok;   // supply good
   logic         reset_pin;   // pin reset
   logic         ictr_en;     // interval counter enable
   logic [3:0]   irq;         // {int0, spi, ictr, pending}
   pmc_axi_req_s req;         // bus requests
   pmc_axi_rsp_s rsp;         // bus answers
   pmc_ctrl_s    ctrl;        // clock and pin controls
   pmc_state_e   mode;        // present mode
   int           err_count;   // mismatches
   int           n_checks;    // comparisons
   int           cyc = 0;     // cycles run

   pmc_ctrl #(.POR_CYCLES(PORC)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .supply_ok(supply_ok), .reset_pin(reset_pin), .irq_pending(irq[0]), .ictr_irq(irq[1]),
      .spi_irq(irq[2]), .ext_int0_irq(irq[3]), .ictr_enable(ictr_en), .ctrl(ctrl), .mode(mode));

   // free-running clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // hang guard, the whole run is well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      `CHK("bresp", OK, rsp.bresp)
   endtask

   // read and compare data and response
   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      `CHK("rdata", e, rsp.rdata)
      `CHK("rresp", er, rsp.rresp)
   endtask

   // wait, bounded, for a mode
   task automatic wm(input pmc_state_e m);
      for (int i = 0; i < 50 && mode !== m; i++) @(posedge aclk);
      `CHK("mode", m, mode)
   endtask

   // controls settle one edge after the mode
   task automatic cc(input logic [10:0] m, input logic [10:0] e);
      repeat (2) @(posedge aclk);
      `CHK("ctrl", e, ctrl & m)
   endtask

   // one-cycle interrupt pulse
   task automatic pl(input logic [3:0] v);
      @(posedge aclk);
      irq <= v;
      @(posedge aclk);
      irq <= 4'h0;
   endtask

   // por length measured from release of the cause
   task automatic pw();
      int t;
      t = 0;
      while (mode !== PMC_ST_RUN && t < 1000) begin
         @(posedge aclk);
         t++;
      end
      `CHK("por time", 1'b1, t >= PORC && t <= PORC + 12)
   endtask

   // main sequence
   initial begin
      aresetn = 1'b0;
      supply_ok = 1'b1;
      reset_pin = 1'b0;
      ictr_en = 1'b0;
      irq = 4'h0;
      req = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      pw();
      rc(A_PC, 32'h0, OK);
      rc(A_PLL, 32'h0, OK);
      rc(A_ST, 32'h2, OK);
      rc(12'h010, 32'h0, `PMC_RESP_SLVERR);
      $display("test reset done");
      wr(A_PC, 32'h1);
      wm(PMC_ST_IDLE);
      cc(11'h5bf, 11'h197);
      rc(A_ST, 32'h4, OK);
      wr(A_PC, 32'h2);
      rc(A_PC, 32'h1, OK);
      pl(4'h1);
      wm(PMC_ST_RUN);
      rc(A_PC, 32'h0, OK);
      rc(A_WK, 32'h1, OK);
      wr(A_WK, 32'hf);
      $display("test idle done");
      // oscillator stop set, disabled wakes must not end power-down
      wr(A_PLL, 32'h8);
      wr(A_PC, 32'h2);
      wm(PMC_ST_PDOWN);
      cc(11'h7ff, 11'h019);
      pl(4'h1);
      pl(4'h4);
      pl(4'h8);
      repeat (2) @(posedge aclk);
      `CHK("mode", PMC_ST_PDOWN, mode)
      pl(4'h2);
      wm(PMC_ST_RUN);
      rc(A_PC, 32'h0, OK);
      rc(A_WK, 32'h2, OK);
      wr(A_WK, 32'hf);
      $display("test power-down done");
      // oscillator kept, counter running, enabled spi then int0 wake
      wr(A_PLL, 32'h0);
      ictr_en <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         wr(A_PC, i ? 32'ha : 32'h6);
         wm(PMC_ST_PDOWN);
         cc(11'h7ff, 11'h159);
         pl(i ? 4'h8 : 4'h4);
         wm(PMC_ST_RUN);
         rc(A_WK, i ? 32'h8 : 32'h4, OK);
         wr(A_WK, 32'hf);
      end
      ictr_en <= 1'b0;
      $display("test wake enables done");
      wr(A_PLL, 32'h8);
      wr(A_PC, 32'h2);
      wm(PMC_ST_PDOWN);
      reset_pin <= 1'b1;
      wm(PMC_ST_POR);
      repeat (8) @(posedge aclk);
      reset_pin <= 1'b0;
      pw();
      rc(A_PC, 32'h0, OK);
      rc(A_PLL, 32'h0, OK);
      $display("test pin reset done");
      supply_ok <= 1'b0;
      wm(PMC_ST_POR);
      repeat (8) @(posedge aclk);
      supply_ok <= 1'b1;
      pw();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      pw();
      $display("test supply done");
      end_sim();
   end
endmodule
bind pmc_ctrl pmc_ctrl_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
   .supply_ok(supply_ok), .reset_pin(reset_pin), .irq_pending(irq_pending), .ictr_irq(ictr_irq),
   .spi_irq(spi_irq), .ext_int0_irq(ext_int0_irq), .ctrl(ctrl), .mode(mode));
`default_nettype wire
